// ==== rtl/lpf_pkg.sv ====
// Purpose: Shared constants for the fun-light and probe serial block
// Assumes: Core clock 200 MHz, SPI mode with 16-bit cycles
// Notes: Register offsets are byte addresses on the serial port
package lpf_pkg;
   localparam int unsigned CORE_CLK_HZ = 200_000_000;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CYCLE_BITS = 16;
   localparam logic [6:0] OFS_FUN_LIGHT_CURRENT = 7'h0C;
   localparam logic [6:0] OFS_AUDIO_CONTROL = 7'h0D;
   localparam logic [6:0] OFS_PROBE_CONTROL = 7'h12;
   localparam logic [6:0] OFS_PROBE_RESULT = 7'h13;
   localparam logic [6:0] OFS_SOFT_RESET = 7'h60;
   localparam int unsigned AUDIO_SYNC_BIT = 2;
   localparam int unsigned PROBE_EN_BIT = 4;
   localparam int unsigned PROBE_SEL_LSB = 0;
   localparam int unsigned PROBE_SEL_W = 4;
   localparam logic [3:0] SEL_LAST_RGB = 4'hB;
   localparam logic [3:0] SEL_FUN_LIGHT = 4'hC;
   localparam logic [3:0] SEL_BOOST = 4'hF;
   localparam int unsigned PROBE_PERIOD_NS = 128_000;
   localparam int unsigned PROBE_PERIOD_CYC = (PROBE_PERIOD_NS / 1000) * (CORE_CLK_HZ / 1_000_000);
   localparam logic [7:0] RESET_VALUE = 8'h00;
endpackage

// ==== rtl/lpf_spi_shift.sv ====
// Purpose: Serial slave shifter for 16-bit address, direction, data cycles
// Assumes: Serial pins already synchronised to the core clock
// Notes: Write strobe fires only after the sixteenth rising edge
module lpf_spi_shift (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_sck,
   input wire logic i_ss_n,
   input wire logic i_si,
   input wire logic [7:0] i_rd_data,
   output logic [6:0] o_addr,
   output logic o_wr_stb,
   output logic [7:0] o_wr_data,
   output logic o_so,
   output logic o_so_oe
);
   logic sck_d_r;
   logic [4:0] cnt_r;
   logic [15:0] sh_r;
   logic [7:0] tx_r;
   logic rd_r;
   logic so_r;
   logic oe_r;
   logic wr_stb_r;
   logic [7:0] wr_data_r;
   logic [6:0] addr_r;
   wire rise = i_sck & ~sck_d_r;
   wire fall = ~i_sck & sck_d_r;
   wire [15:0] sh_nxt = {sh_r[14:0], i_si};
   wire [4:0] cnt_nxt = cnt_r + 5'h01;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sck_d_r <= 1'b0;
         cnt_r <= 5'h00;
         sh_r <= 16'h0000;
         tx_r <= 8'h00;
         rd_r <= 1'b0;
         so_r <= 1'b0;
         oe_r <= 1'b0;
         wr_stb_r <= 1'b0;
         wr_data_r <= 8'h00;
         addr_r <= 7'h00;
      end else begin
         sck_d_r <= i_sck;
         wr_stb_r <= 1'b0;
         if (i_ss_n) begin
            cnt_r <= 5'h00;
            rd_r <= 1'b0;
            oe_r <= 1'b0;
         end else begin
            if (rise && cnt_r < 5'(lpf_pkg::CYCLE_BITS)) begin
               sh_r <= sh_nxt;
               cnt_r <= cnt_nxt;
               if (cnt_r == 5'h06) begin
                  addr_r <= sh_nxt[6:0];
               end
               if (cnt_r == 5'h07) begin
                  rd_r <= ~i_si;
                  tx_r <= i_rd_data;
               end
               if (cnt_r == 5'h0F && !rd_r) begin
                  wr_stb_r <= 1'b1;
                  wr_data_r <= sh_nxt[7:0];
               end
            end
            if (fall && rd_r && cnt_r >= 5'h08 && cnt_r < 5'(lpf_pkg::CYCLE_BITS)) begin
               so_r <= tx_r[7];
               tx_r <= {tx_r[6:0], 1'b0};
               oe_r <= 1'b1;
            end else if (fall) begin
               oe_r <= 1'b0;
            end
         end
      end
   end

   // Address held from seventh bit to cycle end
   assign o_addr = addr_r;
   assign o_wr_stb = wr_stb_r;
   assign o_wr_data = wr_data_r;
   assign o_so = so_r;
   assign o_so_oe = oe_r;
endmodule

// ==== rtl/lpf_top.sv ====
// Purpose: Fun-light current control and pin voltage probe behind serial port
// Assumes: Analog sink, multiplexer and converter sit outside this block
// Notes: Two-wire port is not built; its select only disables the serial port
// Function
// - Sink current from byte unless audio sync
// - Driver on if sync or byte nonzero
// - Current linear in byte at 0x0C
// - Four-bit select routes output to converter
// - Enable starts conversion, result after 128us
// - Repeat conversion every 128us while enabled
// - Latest result readable at 0x13
// - Any write to 0x60 resets device
// - Select pin high picks serial port
// - Cycle is 7 address, direction, 8 data
// - Direction one writes, zero reads
// - Output high-impedance except read data
// - Deselect resets serial port state
// - Sample rising, drive out falling edge
// - Audio sync enable bit in 0x0D
module lpf_top #(
   parameter int unsigned PROBE_PERIOD_CYC = lpf_pkg::PROBE_PERIOD_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_if_select,
   input wire logic i_sck,
   input wire logic i_ss_n,
   input wire logic i_si,
   input wire logic [7:0] i_adc_code,
   output logic o_so,
   output logic o_so_oe,
   output logic [7:0] o_fun_light_current_code,
   output logic o_fun_light_enable,
   output logic o_audio_sync_enable,
   output logic [3:0] o_probe_select,
   output logic o_probe_route_valid,
   output logic o_probe_adc_enable,
   output logic o_probe_sample
);
   logic [1:0] sel_s_r;
   logic [1:0] sck_s_r;
   logic [1:0] ss_s_r;
   logic [1:0] si_s_r;
   logic [7:0] fun_r;
   logic [7:0] audio_r;
   logic [7:0] probe_r;
   logic [7:0] result_r;
   logic [17:0] tick_r;
   logic soft_rst_r;
   logic [6:0] addr;
   logic wr_stb;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic so_raw;
   logic so_oe_raw;

   // True when the latched address names a register
   function automatic logic ofs_hit(input logic [6:0] a, input logic [6:0] ofs);
      return a == ofs;
   endfunction

   // True for select codes wired to a pin
   function automatic logic sel_routed(input logic [3:0] code);
      return (code <= lpf_pkg::SEL_LAST_RGB) | (code == lpf_pkg::SEL_FUN_LIGHT)
         | (code == lpf_pkg::SEL_BOOST);
   endfunction

   // Soft reset is applied as an async clear for one cycle
   wire rst_n = i_resetn & ~soft_rst_r;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sel_s_r <= 2'b00;
         sck_s_r <= 2'b00;
         ss_s_r <= 2'b11;
         si_s_r <= 2'b00;
      end else begin
         sel_s_r <= {sel_s_r[0], i_if_select};
         sck_s_r <= {sck_s_r[0], i_sck};
         ss_s_r <= {ss_s_r[0], i_ss_n};
         si_s_r <= {si_s_r[0], i_si};
      end
   end

   // low select keeps serial port idle
   wire spi_mode = sel_s_r[1];
   wire ss_eff_n = ss_s_r[1] | ~spi_mode;

   lpf_spi_shift u_shift (
      .i_core_clk(i_core_clk),
      .i_resetn(rst_n),
      .i_sck(sck_s_r[1]),
      .i_ss_n(ss_eff_n),
      .i_si(si_s_r[1]),
      .i_rd_data(rd_data),
      .o_addr(addr),
      .o_wr_stb(wr_stb),
      .o_wr_data(wr_data),
      .o_so(so_raw),
      .o_so_oe(so_oe_raw)
   );

   // Address decode shared by write strobes and read mux
   wire hit_fun = ofs_hit(addr, lpf_pkg::OFS_FUN_LIGHT_CURRENT);
   wire hit_audio = ofs_hit(addr, lpf_pkg::OFS_AUDIO_CONTROL);
   wire hit_probe = ofs_hit(addr, lpf_pkg::OFS_PROBE_CONTROL);
   wire hit_result = ofs_hit(addr, lpf_pkg::OFS_PROBE_RESULT);
   wire hit_reset = ofs_hit(addr, lpf_pkg::OFS_SOFT_RESET);

   wire wr_fun = wr_stb & hit_fun;
   wire wr_audio = wr_stb & hit_audio;
   wire wr_probe = wr_stb & hit_probe;
   wire wr_reset = wr_stb & hit_reset;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= wr_reset;
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fun_r <= lpf_pkg::RESET_VALUE;
      end else if (wr_fun) begin
         fun_r <= wr_data;
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         audio_r <= lpf_pkg::RESET_VALUE;
      end else if (wr_audio) begin
         audio_r <= wr_data;
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         probe_r <= lpf_pkg::RESET_VALUE;
      end else if (wr_probe) begin
         probe_r <= wr_data;
      end
   end

   assign rd_data = ({8{hit_fun}} & fun_r) | ({8{hit_audio}} & audio_r)
      | ({8{hit_probe}} & probe_r) | ({8{hit_result}} & result_r);

   wire sync_on = audio_r[lpf_pkg::AUDIO_SYNC_BIT];
   wire probe_on = probe_r[lpf_pkg::PROBE_EN_BIT];
   wire [3:0] sel = probe_r[lpf_pkg::PROBE_SEL_LSB +: lpf_pkg::PROBE_SEL_W];
   wire tick_done = tick_r == 18'(PROBE_PERIOD_CYC - 1);

   // first result one period after enable
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_r <= 18'h00000;
         result_r <= 8'h00;
      end else if (!probe_on) begin
         tick_r <= 18'h00000;
      end else if (tick_done) begin
         tick_r <= 18'h00000;
         result_r <= i_adc_code;
      end else begin
         tick_r <= tick_r + 18'h00001;
      end
   end

   assign o_fun_light_current_code = sync_on ? 8'h00 : fun_r;
   // enable on sync or nonzero byte
   assign o_fun_light_enable = sync_on | (fun_r != 8'h00);
   assign o_audio_sync_enable = sync_on;
   assign o_probe_select = sel;
   assign o_probe_route_valid = sel_routed(sel);
   assign o_probe_adc_enable = probe_on;
   assign o_probe_sample = probe_on & tick_done;
   // driven only while shifting read data
   assign o_so = so_raw;
   assign o_so_oe = so_oe_raw & spi_mode;
endmodule

// ==== tb/lpf_top_checker.sv ====
// Purpose: Port assertions for the fun-light and probe block
// Assumes: Serial clock idles low between cycles
// Notes: Bound from the bench top file
module lpf_top_checker #(
   parameter int unsigned PROBE_PERIOD_CYC = lpf_pkg::PROBE_PERIOD_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_sck,
   input wire logic i_ss_n,
   input wire logic o_so,
   input wire logic o_so_oe,
   input wire logic [7:0] o_fun_light_current_code,
   input wire logic o_fun_light_enable,
   input wire logic o_audio_sync_enable,
   input wire logic [3:0] o_probe_select,
   input wire logic o_probe_route_valid,
   input wire logic o_probe_adc_enable,
   input wire logic o_probe_sample
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   int unsigned gap_r;
   // Cycles since enable or last sample
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) gap_r <= 0;
      else if (!o_probe_adc_enable || o_probe_sample) gap_r <= 0;
      else gap_r <= gap_r + 1;
   end
   fl_blank_a: assert property (o_audio_sync_enable |-> o_fun_light_current_code == 8'h00)
      else $error("code not blanked");
   fl_enable_a: assert property (o_fun_light_enable == (o_audio_sync_enable | (|o_fun_light_current_code)))
      else $error("driver enable wrong");
   route_ok_a: assert property (o_probe_route_valid == !(o_probe_select inside {4'hD, 4'hE}))
      else $error("route valid wrong");
   sample_time_a: assert property (o_probe_sample |-> o_probe_adc_enable && gap_r + 3 >= PROBE_PERIOD_CYC && gap_r <= PROBE_PERIOD_CYC + 1)
      else $error("sample off time");
   sample_due_a: assert property (gap_r <= PROBE_PERIOD_CYC + 1)
      else $error("sample missed");
   so_idle_a: assert property (i_ss_n [*5] |-> !o_so_oe)
      else $error("so driven while idle");
   wr_quiet_a: assert property (i_ss_n [*8] |-> $stable(o_fun_light_current_code))
      else $error("code changed idle");
   so_fall_a: assert property ($changed(o_so) |-> !i_sck)
      else $error("so moved while sck high");
endmodule

// ==== tb/lpf_host_model.sv ====
// Purpose: Serial master standing in for the host processor
// Assumes: Serial clock low when idle, 48 ns period
// Notes: Data line inverted after release so stale bits never look valid
module lpf_host_model (
   output logic o_sck,
   output logic o_ss_n,
   output logic o_si,
   input wire logic i_so
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_sck = 1'b0;
      o_ss_n = 1'b1;
      o_si = 1'b1;
   end
   task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] r);
      r = 8'h00;
      #1.3 o_ss_n = 1'b0;
      #48;
      for (int i = 15; i > 15 - n; i--) begin
         o_si = w[i];
         #24 o_sck = 1'b1;
         if (i < 8) r[i] = i_so;
         #24 o_sck = 1'b0;
      end
      #24;
      o_ss_n = 1'b1;
      o_si = ~o_si;
      #96;
   endtask
endmodule

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the fun-light and probe block
// Assumes: Pull-up on the serial output line
// Notes: Probe period shortened to 64 cycles
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned PER = 64;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ifs = 1'b1;
   logic [7:0] adc = 8'h00;
   logic sck, ss_n, si, so, oe, fl_en, sync, rv, aen, smp;
   logic [7:0] code;
   logic [3:0] sel;
   int errors = 0;
   int checks = 0;
   logic [14:0] rows [8] = '{{7'h0C, 8'h00}, {7'h0C, 8'h01}, {7'h0C, 8'hFF}, {7'h12, 8'h0B},
      {7'h12, 8'h0C}, {7'h12, 8'h0D}, {7'h12, 8'h0E}, {7'h12, 8'h1F}};
   always #2.5 clk = ~clk;
   lpf_top #(.PROBE_PERIOD_CYC(PER)) i_dut (.i_core_clk(clk), .i_resetn(rstn),
      .i_if_select(ifs), .i_sck(sck), .i_ss_n(ss_n), .i_si(si), .i_adc_code(adc), .o_so(so),
      .o_so_oe(oe), .o_fun_light_current_code(code), .o_fun_light_enable(fl_en),
      .o_audio_sync_enable(sync), .o_probe_select(sel), .o_probe_route_valid(rv),
      .o_probe_adc_enable(aen), .o_probe_sample(smp));
   lpf_host_model i_host (.o_sck(sck), .o_ss_n(ss_n), .o_si(si), .i_so(oe ? so : 1'b1));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] r;
      i_host.xfer({a, 1'b1, d}, 16, r);
   endtask
   task rd(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] r;
      i_host.xfer({a, 1'b0, 8'h00}, 16, r);
      chk(r, exp);
   endtask
   initial begin
      #100_000;
      errors++;
      end_of_test();
   end
   initial begin
      logic [7:0] d;
      logic [7:0] r;
      int n;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      for (int a = 0; a < 12; a++) begin
         wr(7'(a), 8'hFF);
      end
      wr(7'h0D, 8'h00);
      wr(7'h0E, 8'h00);
      wr(7'h11, 8'hCF);
      rd(7'h0D, 8'h00);
      $display("setup done");
      foreach (rows[k]) begin
         d = rows[k][7:0];
         wr(rows[k][14:8], d);
         rd(rows[k][14:8], d);
         if (rows[k][14:8] == 7'h0C) begin
            chk(code, d);
            chk({7'h00, fl_en}, {7'h00, |d});
         end else begin
            chk({4'h0, sel}, {4'h0, d[3:0]});
            chk({7'h00, rv}, {7'h00, !(d[3:0] inside {4'hD, 4'hE})});
            chk({7'h00, aen}, {7'h00, d[4]});
         end
      end
      $display("rows done");
      wr(7'h0C, 8'h55);
      wr(7'h0D, 8'h04);
      chk({6'h00, sync, fl_en}, 8'h03);
      chk(code, 8'h00);
      wr(7'h0D, 8'h00);
      chk(code, 8'h55);
      $display("sync done");
      @(posedge clk) adc <= 8'h5A;
      wr(7'h12, 8'h00);
      fork
         wr(7'h12, 8'h13);
         begin
            @(negedge clk iff aen);
            n = 0;
            while (!smp) begin
               @(negedge clk);
               n++;
            end
         end
      join
      chk(8'(n + 1), 8'(PER));
      rd(7'h13, 8'h5A);
      @(negedge clk iff smp);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (!smp);
      chk(8'(n), 8'(PER));
      @(posedge clk) adc <= 8'h3C;
      repeat (2 * PER + 12) @(posedge clk);
      rd(7'h13, 8'h3C);
      wr(7'h12, 8'h00);
      @(posedge clk) adc <= 8'h11;
      repeat (2 * PER + 12) @(posedge clk);
      rd(7'h13, 8'h3C);
      $display("probe done");
      wr(7'h0C, 8'h22);
      i_host.xfer({7'h0C, 1'b1, 8'h77}, 15, r);
      rd(7'h0C, 8'h22);
      @(posedge clk) ifs <= 1'b0;
      wr(7'h0C, 8'h33);
      rd(7'h0C, 8'hFF);
      @(posedge clk) ifs <= 1'b1;
      repeat (4) @(posedge clk);
      rd(7'h0C, 8'h22);
      $display("port done");
      wr(7'h12, 8'h1F);
      wr(7'h60, 8'hA5);
      rd(7'h0C, 8'h00);
      chk({7'h00, aen}, 8'h00);
      rd(7'h7F, 8'h00);
      $display("reset done");
      wr(7'h0C, 8'h44);
      @(posedge clk) rstn <= 1'b0;
      repeat (4) @(posedge clk);
      chk(code, 8'h00);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      rd(7'h0C, 8'h00);
      $display("pin reset done");
      end_of_test();
   end
endmodule
bind lpf_top lpf_top_checker #(.PROBE_PERIOD_CYC(PROBE_PERIOD_CYC)) i_chk (
   .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_sck(i_sck), .i_ss_n(i_ss_n), .o_so(o_so),
   .o_so_oe(o_so_oe), .o_fun_light_current_code(o_fun_light_current_code),
   .o_fun_light_enable(o_fun_light_enable), .o_audio_sync_enable(o_audio_sync_enable),
   .o_probe_select(o_probe_select), .o_probe_route_valid(o_probe_route_valid),
   .o_probe_adc_enable(o_probe_adc_enable), .o_probe_sample(o_probe_sample));
